// ==== inc/sfqp_consts.vh ====
// Opcodes, address fields, sizes and timing for the flash command sequencer
`ifndef SFQP_CONSTS_VH
`define SFQP_CONSTS_VH

// ============================================================
// Command opcodes
`define SFQP_OP_WRITE_ENABLE     8'h06
`define SFQP_OP_QDATA_PROG       8'h32
`define SFQP_OP_QDATA_PROG_WIDE  8'h34
`define SFQP_OP_QIN_PROG         8'hC2
`define SFQP_OP_QIN_PROG_WIDE    8'h3E
`define SFQP_OP_OTP_ERASE        8'h44
`define SFQP_OP_OTP_PROG         8'h42
`define SFQP_OP_OTP_READ         8'h48
`define SFQP_OP_DP_ENTER         8'hB9
`define SFQP_OP_DP_RELEASE       8'hAB
`define SFQP_OP_RST_ENABLE       8'h66
`define SFQP_OP_RST_DO           8'h99

// ============================================================
// Address fields and sizes
`define SFQP_AREA_HI             13
`define SFQP_AREA_LO             12
`define SFQP_AREA_ZERO_HI        11
`define SFQP_AREA_ZERO_LO        10
`define SFQP_OTP_LAST            10'h3FF
`define SFQP_PAGE_LAST           10'h0FF
`define SFQP_OTP_WORDS           3072
`define SFQP_STAGE_WORDS         1024
`define SFQP_BYTE_CAP            12'hFFF
`define SFQP_SIG_DUMMY_END       12'h004

// ============================================================
// Timing
`define SFQP_CLK_PERIOD_NS       10
`define SFQP_PAGE_WRITE_TIME_NS  100000
`define SFQP_AREA_ERASE_TIME_NS  1000000
`define SFQP_DP_ENTRY_TIME_NS    3000
`define SFQP_DP_ENTRY_CYCLES     ((`SFQP_DP_ENTRY_TIME_NS + `SFQP_CLK_PERIOD_NS - 1) / `SFQP_CLK_PERIOD_NS)

// ============================================================
// Pin reset value and output-enable patterns
`define SFQP_PIN_RESET           6'h02
`define SFQP_OE_SPI              4'h2
`define SFQP_OE_QPI              4'hF

`endif

// ==== hw/sfqp_flash.v ====
// Flash command sequencer: quad program, OTP areas, deep power-down, with write FIFO
`timescale 1ns/10ps
`default_nettype none
`include "sfqp_consts.vh"

// ============================================================
// Write FIFO towards the main array
module sfqp_fifo
#(
	parameter WIDTH = 40,
	parameter DEPTH = 4,
	parameter AW    = 2
)
(
	input  wire             clk,
	input  wire             rstN,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	localparam [AW:0] FULL = DEPTH;

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wrPtr_r;
	reg  [AW-1:0]    rdPtr_r;
	reg  [AW:0]      count_r;
	wire             push;
	wire             pop;

	// Handshakes; depth must be a power of two for pointer wrap
	assign inReady  = (count_r != FULL);
	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr_r];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Storage
	always @(posedge clk)
	begin
		if (push)
			mem[wrPtr_r] <= inData;
	end

	// Pointers and fill level
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wrPtr_r <= wrPtr_r + 1'b1;
			if (pop)
				rdPtr_r <= rdPtr_r + 1'b1;
			if (push & !pop)
				count_r <= count_r + 1'b1;
			else if (pop & !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

// ============================================================
// Functional notes
// - 34H program always takes four address bytes
// - C2H needs write latch and quad gate
// - C2H address and data on four lines
// - 3EH program always takes four address bytes
// - Three 1024-byte areas, selected by bits 13:12
// - Area erase 44H needs write latch set
// - Erase ends on byte boundary or discarded
// - Erase sets progress bit until done
// - Locked area ignores erase
// - Area program 42H, 1..1024 bytes, needs latch
// - Area program runs one page-write time
// - Locked area ignores program
// - Area read: address, dummy byte, then data
// - Read address wraps at 3FFH until deselect
// - B9H then deselect enters power-down
// - Power-down entered after fixed entry delay
// - Power-down ignores all but release, signature, reset
// - Release only with exactly eight opcode bits
// - Power-up always starts in standby
// - 66H then 99H wakes from power-down
// - 32H address on line zero, data quad
// - Page keeps last 256 bytes, wraps in page
// - Cycle end clears progress and write latch
module sfqp_flash
#(
	parameter PAGE_WRITE_CYCLES = (`SFQP_PAGE_WRITE_TIME_NS + `SFQP_CLK_PERIOD_NS - 1) / `SFQP_CLK_PERIOD_NS,
	parameter AREA_ERASE_CYCLES = (`SFQP_AREA_ERASE_TIME_NS + `SFQP_CLK_PERIOD_NS - 1) / `SFQP_CLK_PERIOD_NS,
	parameter [7:0] SIGNATURE_ID = 8'h5A // Arbitrary value
)
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        sclk,
	input  wire        csN,
	input  wire [3:0]  ioIn,
	output reg  [3:0]  ioOut,
	output reg  [3:0]  ioOe,
	input  wire        addrWideMode,
	input  wire        qpiMode,
	input  wire        quadGateBit,
	input  wire [2:0]  otpLockBits,
	output wire        writeLatchBit,
	output wire        progressBit,
	output wire        deepPowerDown,
	output wire [31:0] arrWrAddr,
	output wire [7:0]  arrWrData,
	output wire        arrWrValid,
	input  wire        arrWrReady
);
	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_BUSY   = 2'h1;
	localparam [1:0] ST_DPWAIT = 2'h2;
	localparam [1:0] ST_DP     = 2'h3;
	localparam [1:0] JOB_PAGE  = 2'h0;
	localparam [1:0] JOB_OPROG = 2'h1;
	localparam [1:0] JOB_ERASE = 2'h2;

	reg  [1:0]  rstSync_r;
	reg  [5:0]  s1_r, s2_r, s3_r, flt_r, fltPrev_r;
	reg  [1:0]  state_r, job_r;
	reg  [31:0] cnt_r, addr_r, jobAddr_r;
	reg  [7:0]  op_r, rx_r, txSh_r;
	reg  [2:0]  bitCnt_r, txCnt_r;
	reg  [11:0] byteCnt_r;
	reg  [9:0]  curIdx_r, rdAddr_r, drainIdx_r;
	reg         latch_r, rstArm_r, outAct_r, drainDone_r;
	reg  [1023:0] valid_r;
	reg  [7:0]  stageMem [0:`SFQP_STAGE_WORDS-1];
	reg  [7:0]  otpMem   [0:`SFQP_OTP_WORDS-1];
	wire        rstN = rstSync_r[1];

	// Reset release through two flops
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync_r <= 2'h0;
		else
			rstSync_r <= {rstSync_r[0], 1'b1};
	end

	// ============================================================
	// Pin sampling: three flops, change taken when stages two and three agree
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			s1_r      <= `SFQP_PIN_RESET;
			s2_r      <= `SFQP_PIN_RESET;
			s3_r      <= `SFQP_PIN_RESET;
			flt_r     <= `SFQP_PIN_RESET;
			fltPrev_r <= `SFQP_PIN_RESET;
		end
		else
		begin
			s1_r      <= {ioIn, csN, sclk};
			s2_r      <= s1_r;
			s3_r      <= s2_r;
			flt_r     <= (flt_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
			fltPrev_r <= flt_r;
		end
	end

	wire       selected = ~flt_r[1];
	wire       sclkRise = selected & flt_r[0] & ~fltPrev_r[0];
	wire       sclkFall = selected & ~flt_r[0] & fltPrev_r[0];
	wire       csRise   = flt_r[1] & ~fltPrev_r[1];
	wire       csFall   = ~flt_r[1] & fltPrev_r[1];
	wire [3:0] ioS      = flt_r[5:2];

	// ============================================================
	// Opcode decode
	wire isWren   = op_r == `SFQP_OP_WRITE_ENABLE;
	wire isQData  = (op_r == `SFQP_OP_QDATA_PROG) | (op_r == `SFQP_OP_QDATA_PROG_WIDE);
	wire isQIn    = (op_r == `SFQP_OP_QIN_PROG) | (op_r == `SFQP_OP_QIN_PROG_WIDE);
	wire isOProg  = op_r == `SFQP_OP_OTP_PROG;
	wire isOErase = op_r == `SFQP_OP_OTP_ERASE;
	wire isORead  = op_r == `SFQP_OP_OTP_READ;
	wire isDpIn   = op_r == `SFQP_OP_DP_ENTER;
	wire isDpOut  = op_r == `SFQP_OP_DP_RELEASE;
	wire isRstEn  = op_r == `SFQP_OP_RST_ENABLE;
	wire isRstDo  = op_r == `SFQP_OP_RST_DO;
	wire isOtp    = isOProg | isOErase | isORead;
	wire forceWide = (op_r == `SFQP_OP_QDATA_PROG_WIDE) | (op_r == `SFQP_OP_QIN_PROG_WIDE);
	wire [11:0] hdrLen = (forceWide | addrWideMode) ? 12'h005 : 12'h004;
	wire inOp   = byteCnt_r == 12'h000;
	wire inAddr = !inOp & (byteCnt_r < hdrLen);
	// only release, signature and reset pass in power-down
	wire allowed = (state_r == ST_IDLE) | ((state_r == ST_DP) & (isDpOut | isRstEn | isRstDo));
	// quad-in address and data on all four lines
	// 32H address on line zero, data on four
	// read header stays single line outside QPI
	wire wide = qpiMode | (!inOp & (inAddr ? isQIn : (isQIn | isQData)));

	// Byte assembly from incoming bits, MSB first
	wire [7:0] rxNew   = wide ? {rx_r[3:0], ioS} : {rx_r[6:0], ioS[0]};
	wire [2:0] bitNext = bitCnt_r + (wide ? 3'h4 : 3'h1);
	wire       byteDone = sclkRise & (bitNext == 3'h0);
	wire [31:0] addrNew = {addr_r[23:0], rxNew};
	wire       isProg  = isQData | isQIn | isOProg;
	wire [9:0] idxMask = isOProg ? `SFQP_OTP_LAST : `SFQP_PAGE_LAST;

	// area select in bits 13:12, other high bits zero
	wire [1:0] area   = addr_r[`SFQP_AREA_HI:`SFQP_AREA_LO];
	wire       areaOk = (addr_r[31:14] == 18'h0_0000) & (area != 2'h0) &
	                    (addr_r[`SFQP_AREA_ZERO_HI:`SFQP_AREA_ZERO_LO] == 2'h0);
	wire [1:0] areaM1 = area - 2'h1;
	wire       locked = otpLockBits[areaM1];
	wire       boundary = bitCnt_r == 3'h0;

	// ============================================================
	// Command acceptance at deselect
	// erase needs header exactly, byte boundary
	wire okErase = isOErase & (byteCnt_r == hdrLen) & boundary & latch_r & areaOk & !locked;
	// quad programs need write latch and quad gate
	// area program needs latch and one data byte
	wire okProg  = isProg & (byteCnt_r > hdrLen) & boundary & latch_r &
	               ((isQData | isQIn) ? quadGateBit : (areaOk & !locked));
	// release only after exactly eight bits
	wire oneByte = (byteCnt_r == 12'h001) & boundary;

	// Stage buffer fill during the frame
	always @(posedge clk)
	begin
		if (byteDone & !inOp & !inAddr & isProg & allowed)
			stageMem[curIdx_r] <= rxNew;
	end

	// ============================================================
	// Frame receive, read start and stage bookkeeping
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			op_r      <= 8'h00;
			rx_r      <= 8'h00;
			bitCnt_r  <= 3'h0;
			byteCnt_r <= 12'h000;
			addr_r    <= 32'h0000_0000;
			curIdx_r  <= 10'h000;
			outAct_r  <= 1'b0;
			valid_r   <= {1024{1'b0}};
		end
		else if (csFall)
		begin
			bitCnt_r  <= 3'h0;
			byteCnt_r <= 12'h000;
			addr_r    <= 32'h0000_0000;
			outAct_r  <= 1'b0;
			op_r      <= 8'h00;
			if (state_r == ST_IDLE)
				valid_r <= {1024{1'b0}};
		end
		else if (sclkRise & !outAct_r)
		begin
			rx_r     <= rxNew;
			bitCnt_r <= bitNext;
			if (byteDone)
			begin
				if (byteCnt_r != `SFQP_BYTE_CAP)
					byteCnt_r <= byteCnt_r + 12'h001;
				if (inOp)
					op_r <= rxNew;
				else if (inAddr)
				begin
					addr_r <= addrNew;
					// page index wraps inside 256 bytes
					curIdx_r <= addrNew[9:0] & idxMask;
				end
				else if (isProg & allowed)
				begin
					valid_r[curIdx_r] <= 1'b1;
					// area data wraps inside 1024 bytes
					curIdx_r <= (curIdx_r + 10'h001) & idxMask;
				end
				// area data follows address and one dummy byte; signature follows three dummy bytes
				if (allowed & isORead & (byteCnt_r == hdrLen))
					outAct_r <= 1'b1;
				if (allowed & isDpOut & (byteCnt_r == `SFQP_SIG_DUMMY_END - 12'h001))
					outAct_r <= 1'b1;
			end
		end
	end

	// ============================================================
	// Serial output on falling clock edges
	wire [7:0] otpByte = (areaOk & isOtp) ? otpMem[{areaM1, rdAddr_r}] : 8'hFF;
	wire [7:0] curByte = isDpOut ? SIGNATURE_ID : otpByte;
	wire [7:0] txSrc   = (txCnt_r == 3'h0) ? curByte : txSh_r;

	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			ioOut    <= 4'h0;
			ioOe     <= 4'h0;
			txSh_r   <= 8'h00;
			txCnt_r  <= 3'h0;
			rdAddr_r <= 10'h000;
		end
		else if (!selected | !outAct_r)
		begin
			ioOe     <= 4'h0;
			txCnt_r  <= 3'h0;
			rdAddr_r <= addr_r[9:0];
		end
		else if (sclkFall)
		begin
			ioOe <= qpiMode ? `SFQP_OE_QPI : `SFQP_OE_SPI;
			if (qpiMode)
			begin
				ioOut   <= txSrc[7:4];
				txSh_r  <= {txSrc[3:0], 4'h0};
				txCnt_r <= (txCnt_r == 3'h0) ? 3'h1 : 3'h0;
			end
			else
			begin
				ioOut   <= {2'h0, txSrc[7], 1'b0};
				txSh_r  <= {txSrc[6:0], 1'b0};
				txCnt_r <= (txCnt_r == 3'h0) ? 3'h7 : txCnt_r - 3'h1;
			end
			// low ten address bits wrap 3FFH to 000H
			if (txCnt_r == 3'h0)
				rdAddr_r <= rdAddr_r + 10'h001;
		end
	end

	// ============================================================
	// Drain of the stage buffer during a program or erase cycle
	wire       busy      = state_r == ST_BUSY;
	wire [9:0] drainLast = (job_r == JOB_PAGE) ? `SFQP_PAGE_LAST : `SFQP_OTP_LAST;
	wire       drainLive = busy & !drainDone_r;
	wire       curValid  = valid_r[drainIdx_r];
	wire [7:0] stageByte = stageMem[drainIdx_r];
	wire       fifoReady;
	wire       fifoPush  = drainLive & (job_r == JOB_PAGE) & curValid;
	// Back-pressure from the array holds the drain index
	wire       drainStep = drainLive & (!fifoPush | fifoReady);
	wire [1:0] jobArea   = jobAddr_r[`SFQP_AREA_HI:`SFQP_AREA_LO] - 2'h1;
	wire       otpWrEn   = drainLive & ((job_r == JOB_ERASE) | ((job_r == JOB_OPROG) & curValid));
	wire [11:0] otpWrIdx = {jobArea, drainIdx_r};
	// Programming only clears bits; erase sets them all
	wire [7:0] otpWrData = (job_r == JOB_ERASE) ? 8'hFF : (otpMem[otpWrIdx] & stageByte);

	always @(posedge clk)
	begin
		if (otpWrEn)
			otpMem[otpWrIdx] <= otpWrData;
	end

	sfqp_fifo
	#(
		.WIDTH (40),
		.DEPTH (4),
		.AW    (2)
	)
	u_fifo
	(
		.clk      (clk),
		.rstN     (rstN),
		.inData   ({jobAddr_r[31:8], drainIdx_r[7:0], stageByte}),
		.inValid  (fifoPush),
		.inReady  (fifoReady),
		.outData  ({arrWrAddr, arrWrData}),
		.outValid (arrWrValid),
		.outReady (arrWrReady)
	);

	// ============================================================
	// Operating state, timers and write latch
	// power-up reset lands in standby
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			state_r     <= ST_IDLE;
			job_r       <= JOB_PAGE;
			cnt_r       <= 32'h0000_0000;
			jobAddr_r   <= 32'h0000_0000;
			latch_r     <= 1'b0;
			rstArm_r    <= 1'b0;
			drainIdx_r  <= 10'h000;
			drainDone_r <= 1'b0;
		end
		else
		begin
			if (drainStep)
			begin
				drainIdx_r <= drainIdx_r + 10'h001;
				if (drainIdx_r == drainLast)
					drainDone_r <= 1'b1;
			end
			if (state_r != ST_IDLE && state_r != ST_DP && cnt_r != 32'h0000_0000)
				cnt_r <= cnt_r - 32'h0000_0001;
			case (state_r)
				ST_IDLE:
				begin
					if (csRise)
					begin
						rstArm_r <= isRstEn & oneByte;
						if (isWren & oneByte)
							latch_r <= 1'b1;
						if (isDpIn & oneByte)
						begin
							state_r <= ST_DPWAIT;
							cnt_r   <= `SFQP_DP_ENTRY_CYCLES;
						end
						if (okErase | okProg)
						begin
							state_r     <= ST_BUSY;
							job_r       <= okErase ? JOB_ERASE : (isOProg ? JOB_OPROG : JOB_PAGE);
							// area program lasts one page-write time
							cnt_r       <= okErase ? AREA_ERASE_CYCLES : PAGE_WRITE_CYCLES;
							jobAddr_r   <= addr_r;
							drainIdx_r  <= (okProg & !isOProg) ? 10'h000 : 10'h000;
							drainDone_r <= 1'b0;
						end
						if (isRstDo & oneByte & rstArm_r)
							latch_r <= 1'b0;
					end
				end
				ST_BUSY:
				begin
					// cycle end clears progress and latch
					if (cnt_r == 32'h0000_0000 && drainDone_r)
					begin
						state_r <= ST_IDLE;
						latch_r <= 1'b0;
					end
				end
				ST_DPWAIT:
				begin
					if (cnt_r == 32'h0000_0000)
						state_r <= ST_DP;
				end
				ST_DP:
				begin
					if (csRise)
					begin
						rstArm_r <= isRstEn & oneByte;
						// release needs exactly one opcode byte
						if (isDpOut & oneByte)
							state_r <= ST_IDLE;
						if (isRstDo & oneByte & rstArm_r)
						begin
							state_r <= ST_IDLE;
							latch_r <= 1'b0;
						end
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Status outputs
	assign writeLatchBit = latch_r;
	assign progressBit   = busy;
	assign deepPowerDown = state_r == ST_DP;
endmodule
`default_nettype wire

// ==== dv/sfqp_flash_checker.sv ====
// Concurrent checks on the ports of the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sfqp_consts.vh"

// ============================================================
// Checker
module sfqp_flash_checker
#(
	parameter PAGE_WRITE_CYCLES = 1200,
	parameter AREA_ERASE_CYCLES = 1200
)
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        csN,
	input wire logic        qpiMode,
	input wire logic [3:0]  ioOe,
	input wire logic        writeLatchBit,
	input wire logic        progressBit,
	input wire logic        deepPowerDown,
	input wire logic [31:0] arrWrAddr,
	input wire logic [7:0]  arrWrData,
	input wire logic        arrWrValid,
	input wire logic        arrWrReady
);
	localparam int MIN_BUSY = (PAGE_WRITE_CYCLES < AREA_ERASE_CYCLES) ? PAGE_WRITE_CYCLES : AREA_ERASE_CYCLES;
	localparam int DP_WAIT  = `SFQP_DP_ENTRY_CYCLES;
	int busyCnt_r;
	int csHiCnt_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Length of the busy cycle, and of the deselect gap saturating at 100000
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busyCnt_r <= 0;
			csHiCnt_r <= 0;
		end
		else
		begin
			busyCnt_r <= progressBit ? busyCnt_r + 1 : 0;
			csHiCnt_r <= !csN ? 0 : ((csHiCnt_r < 100000) ? csHiCnt_r + 1 : csHiCnt_r);
		end
	end

	// ============================================================
	// Assertions
	a_reset_quiet: assert property ($rose(rst_n) |-> !progressBit && !writeLatchBit && !deepPowerDown && !arrWrValid)
		else $error("outputs not idle after reset");
	a_busy_length: assert property ($fell(progressBit) |-> busyCnt_r >= MIN_BUSY - 1)
		else $error("busy cycle too short");
	a_latch_cleared: assert property ($fell(progressBit) |-> !writeLatchBit)
		else $error("latch kept after cycle end");
	a_busy_needs_latch: assert property ($rose(progressBit) |-> writeLatchBit)
		else $error("cycle started without latch");
	a_busy_on_deselect: assert property ($rose(progressBit) |-> csN && csHiCnt_r <= 10)
		else $error("cycle not started by deselect");
	a_dp_delay: assert property ($rose(deepPowerDown) |-> csHiCnt_r >= DP_WAIT)
		else $error("power-down entered early");
	a_dp_no_latch: assert property ($rose(writeLatchBit) |-> !deepPowerDown)
		else $error("latch set in power-down");
	a_dp_no_busy: assert property (deepPowerDown |-> !progressBit)
		else $error("busy in power-down");
	a_oe_idle: assert property (csN [*8] |-> ioOe == 4'h0)
		else $error("lines driven while deselected");
	a_oe_lines: assert property (ioOe != 4'h0 |-> ioOe == (qpiMode ? 4'hF : 4'h2))
		else $error("wrong output lines enabled");
	a_fifo_hold: assert property (arrWrValid && !arrWrReady |=> arrWrValid && $stable(arrWrAddr) && $stable(arrWrData))
		else $error("array write changed while stalled");

	// Main scenarios reached
	cover property ($rose(progressBit));
	cover property ($rose(deepPowerDown));
	cover property (arrWrValid && !arrWrReady);
endmodule

bind sfqp_flash sfqp_flash_checker #(.PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES), .AREA_ERASE_CYCLES(AREA_ERASE_CYCLES)) chk (
	.clk(clk), .rst_n(rst_n), .csN(csN), .qpiMode(qpiMode), .ioOe(ioOe), .writeLatchBit(writeLatchBit),
	.progressBit(progressBit), .deepPowerDown(deepPowerDown), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData),
	.arrWrValid(arrWrValid), .arrWrReady(arrWrReady)
);
`default_nettype wire

// ==== dv/sfqp_host_model.sv ====
// Host controller model driving the serial link of the flash sequencer
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Serial host, mode 0, clock parked low outside frames
module sfqp_host_model
(
	output logic             csN,
	output logic             sclk,
	output wire logic [3:0]  ioIn,
	input wire logic  [3:0]  ioOut,
	input wire logic  [3:0]  ioOe
);
	logic [3:0] drv;

	// Each line shows whoever enables it
	assign ioIn = (ioOe & ioOut) | (~ioOe & drv);

	// Idle: deselected
	initial
	begin
		csN = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
	end

	task automatic start();
		csN = 1'b0;
		#40;
	endtask

	// MSB first, changed on the falling edge
	task automatic xfer(input logic [31:0] v, input int nBits, input int w);
		for (int i = nBits - w; i >= 0; i -= w)
		begin
			drv = (w == 4) ? v[i +: 4] : {drv[3:1], v[i]};
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
	endtask

	// sample late in the high phase, device shifts on the fall
	task automatic rd(output logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			#40 sclk = 1'b1;
			#35 b = {b[6:0], ioIn[1]};
			#5 sclk = 1'b0;
		end
	endtask

	// deselect after the last clock, byte boundary or not; released lines show a stale inverse
	task automatic stop();
		#40 csN = 1'b1;
		drv = ~drv;
		#120;
	endtask
endmodule
`default_nettype wire

// ==== dv/sfqp_flash_test.sv ====
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sfqp_consts.vh"

// ============================================================
// Bench top
module sfqp_flash_test;
	localparam int PWC = 1200;
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	wire logic        csN;
	wire logic        sclk;
	wire logic [3:0]  ioIn;
	wire logic [3:0]  ioOut;
	wire logic [3:0]  ioOe;
	logic             addrWideMode = 1'b0;
	logic             qpiMode = 1'b0;
	logic             quadGateBit = 1'b0;
	logic [2:0]       otpLockBits = 3'h0;
	wire logic        writeLatchBit;
	wire logic        progressBit;
	wire logic        deepPowerDown;
	wire logic [31:0] arrWrAddr;
	wire logic [7:0]  arrWrData;
	wire logic        arrWrValid;
	logic             arrWrReady = 1'b0;
	logic             stall = 1'b0;
	int               num_errors = 0;
	int               num_checks = 0;
	int               cyc = 0;
	logic [7:0]       rnd = 8'h0A;
	logic [7:0]       rndRdy = 8'h0A;
	logic [39:0]      expQ [$];
	logic [7:0]       d [3];
	logic [7:0]       dat [256];
	logic [255:0]     used;
	logic [7:0]       qop [5];
	logic [7:0]       c;
	logic [7:0]       ix;
	logic [31:0]      a;
	logic             wide;

	sfqp_flash #(.PAGE_WRITE_CYCLES(PWC), .AREA_ERASE_CYCLES(PWC)) uut (
		.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
		.addrWideMode(addrWideMode), .qpiMode(qpiMode), .quadGateBit(quadGateBit), .otpLockBits(otpLockBits),
		.writeLatchBit(writeLatchBit), .progressBit(progressBit), .deepPowerDown(deepPowerDown),
		.arrWrAddr(arrWrAddr), .arrWrData(arrWrData), .arrWrValid(arrWrValid), .arrWrReady(arrWrReady)
	);
	sfqp_host_model h (.csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

	// Clock
	always #5 clk = ~clk;

	// ============================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input string n, input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic hdr(input logic [7:0] op, input logic [31:0] a0, input int nA, input int w);
		h.start();
		h.xfer(op, 8, 1);
		h.xfer(a0, nA, w);
	endtask

	task automatic cmd(input logic [7:0] op);
		h.start();
		h.xfer(op, 8, qpiMode ? 4 : 1);
		h.stop();
	endtask

	// Bounded wait for the cycle to end and the array writes to drain
	task automatic waitDone();
		for (int i = 0; i < 8000 && (progressBit !== 1'b0 || expQ.size() != 0); i++)
			@(posedge clk);
		#1;
		chk("cycle end", {progressBit, expQ.size() != 0}, 2'h0);
	endtask

	task automatic rdA(input logic [31:0] a0, input int n);
		logic [7:0] b;
		hdr(`SFQP_OP_OTP_READ, a0, 24, 1);
		h.xfer(32'h0000_0000, 8, 1);
		for (int i = 0; i < n; i++)
		begin
			h.rd(b);
			chk("area read", b, (i < 3) ? d[i] : 8'hFF);
		end
		h.stop();
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Random drain stalls on the array side, off the sampling edge
	always @(posedge clk)
	begin
		#1 rndRdy = lfsr(rndRdy);
		arrWrReady = !stall && rndRdy[0];
	end

	// Array writes are compared in order against the noted expectations
	always @(posedge clk)
	begin
		if (rst_n === 1'b1 && arrWrValid === 1'b1 && arrWrReady === 1'b1)
		begin
			if (expQ.size() == 0)
				chk("array write unexpected", 1'b1, 1'b0);
			else
				chk("array write", {arrWrAddr, arrWrData}, expQ.pop_front());
		end
	end

	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			num_errors++;
			finish_test();
		end
	end

	// ============================================================
	// Main sequence
	initial
	begin
		qop = '{`SFQP_OP_QIN_PROG, `SFQP_OP_QDATA_PROG, `SFQP_OP_QDATA_PROG_WIDE, `SFQP_OP_QIN_PROG,
			`SFQP_OP_QIN_PROG_WIDE};
		tick(6);
		rst_n = 1'b1;
		tick(4);
		chk("idle", {writeLatchBit, progressBit, deepPowerDown, arrWrValid}, 4'h0);
		// Erase refused without latch, refused off a byte boundary, then accepted
		hdr(`SFQP_OP_OTP_ERASE, 32'h0000_1000, 24, 1);
		h.stop();
		chk("erase no latch", progressBit, 1'b0);
		cmd(`SFQP_OP_WRITE_ENABLE);
		hdr(`SFQP_OP_OTP_ERASE, 32'h0000_1000, 24, 1);
		h.xfer(32'h0000_0000, 4, 1);
		h.stop();
		chk("erase partial", {progressBit, writeLatchBit}, 2'h1);
		hdr(`SFQP_OP_OTP_ERASE, 32'h0000_1000, 24, 1);
		h.stop();
		chk("erase start", progressBit, 1'b1);
		waitDone();
		chk("erase latch", writeLatchBit, 1'b0);
		$display("erase test done");
		// Program across the area end, then read back over the wrap
		for (int i = 0; i < 3; i++)
		begin
			rnd = lfsr(rnd);
			d[i] = rnd;
		end
		cmd(`SFQP_OP_WRITE_ENABLE);
		hdr(`SFQP_OP_OTP_PROG, 32'h0000_13FE, 24, 1);
		for (int i = 0; i < 3; i++)
			h.xfer(d[i], 8, 1);
		h.stop();
		chk("prog start", progressBit, 1'b1);
		waitDone();
		chk("prog latch", writeLatchBit, 1'b0);
		rdA(32'h0000_13FE, 4);
		$display("area program test done");
		// Locked area refuses program and erase, contents kept
		otpLockBits = 3'h1;
		cmd(`SFQP_OP_WRITE_ENABLE);
		hdr(`SFQP_OP_OTP_PROG, 32'h0000_13FE, 24, 1);
		h.xfer(32'h0000_0000, 8, 1);
		h.stop();
		chk("locked prog", {progressBit, writeLatchBit}, 2'h1);
		hdr(`SFQP_OP_OTP_ERASE, 32'h0000_1000, 24, 1);
		h.stop();
		chk("locked erase", {progressBit, writeLatchBit}, 2'h1);
		rdA(32'h0000_13FE, 1);
		otpLockBits = 3'h0;
		$display("lock test done");
		// Quad programs: gate off first, then each opcode with a page wrap
		for (int k = 0; k < 5; k++)
		begin
			c = qop[k];
			quadGateBit = (k != 0);
			addrWideMode = k[0];
			wide = addrWideMode || c == `SFQP_OP_QDATA_PROG_WIDE || c == `SFQP_OP_QIN_PROG_WIDE;
			rnd = lfsr(rnd);
			a = {wide ? rnd : 8'h00, rnd ^ 8'h5A, rnd, 8'hFC};
			cmd(`SFQP_OP_WRITE_ENABLE);
			stall = (k == 1);
			hdr(c, a, wide ? 32 : 24, (c == `SFQP_OP_QIN_PROG || c == `SFQP_OP_QIN_PROG_WIDE) ? 4 : 1);
			used = '0;
			for (int i = 0; i < 6; i++)
			begin
				rnd = lfsr(rnd);
				ix = 8'hFC + i[7:0];
				dat[ix] = rnd;
				used[ix] = 1'b1;
				h.xfer(rnd, 8, 4);
			end
			for (int j = 0; j < 256 && k != 0; j++)
				if (used[j])
					expQ.push_back({a[31:8], j[7:0], dat[j]});
			h.stop();
			chk("quad start", progressBit, k != 0);
			if (stall)
			begin
				tick(1500);
				stall = 1'b0;
			end
			waitDone();
		end
		addrWideMode = 1'b0;
		$display("quad program test done");
		// Power-down: delay, ignored commands, release, software reset, power cycle
		h.start();
		h.stop();
		cmd(`SFQP_OP_DP_ENTER);
		tick(100);
		chk("dp early", deepPowerDown, 1'b0);
		tick(250);
		chk("dp entered", deepPowerDown, 1'b1);
		cmd(`SFQP_OP_WRITE_ENABLE);
		chk("dp ignores", writeLatchBit, 1'b0);
		h.start();
		h.xfer(`SFQP_OP_DP_RELEASE, 8, 1);
		h.xfer(32'h0000_0000, 4, 1);
		h.stop();
		chk("release partial", deepPowerDown, 1'b1);
		cmd(`SFQP_OP_DP_RELEASE);
		chk("released", deepPowerDown, 1'b0);
		qpiMode = 1'b1;
		cmd(`SFQP_OP_DP_ENTER);
		tick(350);
		cmd(`SFQP_OP_RST_ENABLE);
		cmd(`SFQP_OP_RST_DO);
		chk("reset wake", deepPowerDown, 1'b0);
		qpiMode = 1'b0;
		cmd(`SFQP_OP_DP_ENTER);
		tick(350);
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(4);
		chk("power cycle", deepPowerDown, 1'b0);
		$display("power-down test done");
		finish_test();
	end
endmodule
`default_nettype wire
